/* File: design/ictr_defines.svh */
`ifndef ICTR_DEFINES_SVH
`define ICTR_DEFINES_SVH

// register word indices; byte address is four times the index
`define ICTR_IDX_IRQ_FLAG     10'h207
`define ICTR_IDX_CNT_A_DATA   10'h208
`define ICTR_IDX_CNT_B_DATA   10'h209
`define ICTR_IDX_CORE_CTRL    10'h20b
`define ICTR_IDX_CNT_A_START  10'h20c
`define ICTR_IDX_CNT_B_START  10'h20d
`define ICTR_IDX_CNT_A_SET    10'h20e
`define ICTR_IDX_CNT_B_SET    10'h20f

// field positions
`define ICTR_BIT_A_FLAG       2
`define ICTR_BIT_B_FLAG       3
`define ICTR_BIT_SW_GATE      0
`define ICTR_BIT_OUT_STATUS   4
`define ICTR_BIT_CLK_SEL      0
`define ICTR_BIT_GATE_SEL     1
`define ICTR_BIT_OUT_ROUTE    2
`define ICTR_BIT_IRQ_EN       3
`define ICTR_BIT_TB_LO        4
`define ICTR_BIT_TB_HI        5
`define ICTR_BIT_CASCADE      6
`define ICTR_CW_SEL_HI        7
`define ICTR_CW_SEL_LO        6

// reset values
`define ICTR_RST_BYTE         8'h00
`define ICTR_RST_SET_A        4'h0
`define ICTR_RST_SET_B        7'h00
`define ICTR_RST_COUNT        16'h0000
`define ICTR_SYS_RELOAD       16'hffff

// timing
`define ICTR_CLK_HZ           200000000
`define ICTR_TB_100K_HZ       100000
`define ICTR_TB_10K_HZ        10000
`define ICTR_TB_1K_HZ         1000
`define ICTR_TB_100_HZ        100
`define ICTR_TB_W             21

`endif

/* File: design/ictr_pkg.sv */
package ictr_pkg;

  typedef logic [7:0] ictr_byte_t;

  typedef logic [15:0] ictr_count_t;

  // time-base rates, in the order of the two-bit select field
  typedef enum logic [1:0]
  {
    ICTR_TB_100K,
    ICTR_TB_10K,
    ICTR_TB_1K,
    ICTR_TB_100
  } ictr_tb_t;

endpackage

/* File: design/ictr_counter16.sv */
`timescale 1ns/1ps
`include "ictr_defines.svh"

module ictr_counter16
  import ictr_pkg::*;
#(
  parameter ictr_count_t INIT_RELOAD = `ICTR_RST_COUNT,
  parameter bit          INIT_ARMED  = 1'b0
)
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       tick,
  input  wire logic       gate,
  input  wire logic       wr_en,
  input  wire ictr_byte_t wr_data,
  input  wire logic       rd_en,
  input  wire logic       ptr_reset,
  output ictr_byte_t      rd_byte,
  output logic            out_ff,
  output logic            tc_ff
);

  ictr_count_t count_ff;
  ictr_count_t reload_ff;
  ictr_byte_t  lo_hold_ff;
  logic        wr_hi_ff;
  logic        rd_hi_ff;
  logic        armed_ff;

  // low byte first, then high byte; the high byte write loads and arms
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      wr_hi_ff   <= 1'b0;
      lo_hold_ff <= `ICTR_RST_BYTE;
      reload_ff  <= INIT_RELOAD;
    end
    else if (ptr_reset)
    begin
      wr_hi_ff <= 1'b0;
    end
    else if (wr_en)
    begin
      wr_hi_ff <= ~wr_hi_ff;
      if (!wr_hi_ff)
      begin
        lo_hold_ff <= wr_data;
      end
      else
      begin
        reload_ff <= {wr_data, lo_hold_ff};
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      rd_hi_ff <= 1'b0;
    end
    else if (ptr_reset)
    begin
      rd_hi_ff <= 1'b0;
    end
    else if (rd_en)
    begin
      rd_hi_ff <= ~rd_hi_ff;
    end
  end

  assign rd_byte = rd_hi_ff ? count_ff[15:8] : count_ff[7:0];

  // rate-generator style: output low for one tick at count 1, then reload
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      count_ff <= INIT_RELOAD;
      armed_ff <= INIT_ARMED;
      out_ff   <= 1'b1;
      tc_ff    <= 1'b0;
    end
    else if (wr_en && wr_hi_ff && !ptr_reset)
    begin
      count_ff <= {wr_data, lo_hold_ff};
      armed_ff <= 1'b1;
      out_ff   <= 1'b1;
      tc_ff    <= 1'b0;
    end
    else if (armed_ff && tick && gate)
    begin
      if (count_ff <= 16'h0001)
      begin
        count_ff <= reload_ff;
        out_ff   <= 1'b1;
        tc_ff    <= 1'b0;
      end
      else
      begin
        count_ff <= count_ff - 16'h0001;
        out_ff   <= (count_ff != 16'h0002);
        tc_ff    <= (count_ff == 16'h0002);
      end
    end
    else
    begin
      tc_ff <= 1'b0;
    end
  end

endmodule

/* File: design/ictr_top.sv */
// What this block does
// - three 16-bit down counters; only counters zero and one reach software.
// - each user counter takes a programmed count from 2 to 65535.
// - every counter has a clock input, a gate input and a pulse output.
// - counter zero clock is time base, or isolated input one when selected.
// - counter one clock is time base, or isolated input three when selected.
// - time-base field picks 100 kHz, 10 kHz, 1 kHz or 100 Hz.
// - counter zero gate follows software gate bit, or isolated input zero.
// - counter one gate follows software gate bit, or isolated input two.
// - counter zero output drives status, plus isolated output two when routed.
// - counter one output drives status, plus isolated output three when routed.
// - start register holds software gate at bit 0, live output at bit 4.
// - flag register holds counter zero flag bit 2, counter one bit 3.
// - counter zero setting: clock, gate, route, interrupt enable at bits 0-3.
// - counter one setting adds time base at bits 4-5, cascade at bit 6.
// - two data ports pass straight to counter core; control-word writes naming counter two are ignored.
// - counters zero and one can combine into one 32-bit counter.
// - a counter advances on its clock only while its gate is asserted.
// - writes update control bits; reads return live status and flags.
// - writing 1 clears a counter flag; writing 0 does nothing.
// - a counter raises an interrupt only while its enable bit is 1.
// - cascade bit 0 keeps counters separate; 1 joins them into 32 bits.
// - counter interrupts share interrupt line 7 with input interrupts.
`timescale 1ns/1ps
`include "ictr_defines.svh"

module ictr_top
  import ictr_pkg::*;
#(
  parameter int unsigned ADDR_W   = 12,
  parameter int unsigned DIV_100K = `ICTR_CLK_HZ / `ICTR_TB_100K_HZ,
  parameter int unsigned DIV_10K  = `ICTR_CLK_HZ / `ICTR_TB_10K_HZ,
  parameter int unsigned DIV_1K   = `ICTR_CLK_HZ / `ICTR_TB_1K_HZ,
  parameter int unsigned DIV_100  = `ICTR_CLK_HZ / `ICTR_TB_100_HZ
)
(
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              iso_in_ch0,
  input  wire logic              iso_in_ch1,
  input  wire logic              iso_in_ch2,
  input  wire logic              iso_in_ch3,
  input  wire logic              di_irq_req,
  output logic                   iso_out_ch2,
  output logic                   iso_out_ch3,
  output logic                   irq_line7
);

  localparam int unsigned NCNT = 3;

  // ---------------- register state ----------------
  logic       cnt_a_sw_gate_ff;
  logic       cnt_b_sw_gate_ff;
  logic [3:0] set_a_ff;
  logic [6:0] set_b_ff;
  logic       cnt_a_irq_flag_ff;
  logic       cnt_b_irq_flag_ff;
  ictr_byte_t core_ctrl_ff;
  logic       pready_ff;
  logic       pslverr_ff;
  logic [31:0] prdata_ff;
  logic       iso_out_ch2_ff;
  logic       iso_out_ch3_ff;
  logic       irq_line7_ff;

  logic cnt_a_clock_select;
  logic cnt_a_gate_select;
  logic cnt_a_out_route;
  logic cnt_a_irq_enable;
  logic cnt_b_clock_select;
  logic cnt_b_gate_select;
  logic cnt_b_out_route;
  logic cnt_b_irq_enable;
  logic cascade_enable;
  ictr_tb_t timebase_sel;

  assign cnt_a_clock_select = set_a_ff[`ICTR_BIT_CLK_SEL];
  assign cnt_a_gate_select  = set_a_ff[`ICTR_BIT_GATE_SEL];
  assign cnt_a_out_route    = set_a_ff[`ICTR_BIT_OUT_ROUTE];
  assign cnt_a_irq_enable   = set_a_ff[`ICTR_BIT_IRQ_EN];
  assign cnt_b_clock_select = set_b_ff[`ICTR_BIT_CLK_SEL];
  assign cnt_b_gate_select  = set_b_ff[`ICTR_BIT_GATE_SEL];
  assign cnt_b_out_route    = set_b_ff[`ICTR_BIT_OUT_ROUTE];
  assign cnt_b_irq_enable   = set_b_ff[`ICTR_BIT_IRQ_EN];
  assign cascade_enable     = set_b_ff[`ICTR_BIT_CASCADE];
  assign timebase_sel       = ictr_tb_t'(set_b_ff[`ICTR_BIT_TB_HI:`ICTR_BIT_TB_LO]);

  // ---------------- bus decode ----------------
  logic       setup_ph;
  logic       access_done;
  logic       wr_done;
  logic       rd_done;
  logic [9:0] word_idx;
  logic       aligned;
  logic       hit_irq;
  logic       hit_a_data;
  logic       hit_b_data;
  logic       hit_ctrl;
  logic       hit_a_start;
  logic       hit_b_start;
  logic       hit_a_set;
  logic       hit_b_set;
  logic       hit_any;
  ictr_byte_t wbyte;

  assign setup_ph    = psel && !penable && !pready_ff;
  assign access_done = psel && penable && pready_ff;
  assign wr_done     = access_done && pwrite && !pslverr_ff && pstrb[0];
  assign rd_done     = access_done && !pwrite && !pslverr_ff;
  assign word_idx    = paddr[11:2];
  assign aligned     = (paddr[1:0] == 2'b00);
  assign wbyte       = pwdata[7:0];

  assign hit_irq     = aligned && (word_idx == `ICTR_IDX_IRQ_FLAG);
  assign hit_a_data  = aligned && (word_idx == `ICTR_IDX_CNT_A_DATA);
  assign hit_b_data  = aligned && (word_idx == `ICTR_IDX_CNT_B_DATA);
  assign hit_ctrl    = aligned && (word_idx == `ICTR_IDX_CORE_CTRL);
  assign hit_a_start = aligned && (word_idx == `ICTR_IDX_CNT_A_START);
  assign hit_b_start = aligned && (word_idx == `ICTR_IDX_CNT_B_START);
  assign hit_a_set   = aligned && (word_idx == `ICTR_IDX_CNT_A_SET);
  assign hit_b_set   = aligned && (word_idx == `ICTR_IDX_CNT_B_SET);
  assign hit_any     = hit_irq || hit_a_data || hit_b_data || hit_ctrl
                    || hit_a_start || hit_b_start || hit_a_set || hit_b_set;

  // ---------------- input synchronisers ----------------
  logic [3:0] iso_meta_ff;
  logic [3:0] iso_sync_ff;
  logic [3:0] iso_prev_ff;
  logic [3:0] iso_raw;
  logic [3:0] iso_rise;

  assign iso_raw = {iso_in_ch3, iso_in_ch2, iso_in_ch1, iso_in_ch0};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge clock)
      begin
        if (!resetn)
        begin
          iso_meta_ff[gi] <= 1'b0;
          iso_sync_ff[gi] <= 1'b0;
          iso_prev_ff[gi] <= 1'b0;
        end
        else
        begin
          iso_meta_ff[gi] <= iso_raw[gi];
          iso_sync_ff[gi] <= iso_meta_ff[gi];
          iso_prev_ff[gi] <= iso_sync_ff[gi];
        end
      end
      assign iso_rise[gi] = iso_sync_ff[gi] && !iso_prev_ff[gi];
    end
  endgenerate

  // ---------------- internal time base ----------------
  logic [`ICTR_TB_W-1:0] tb_cnt_ff;
  logic [`ICTR_TB_W-1:0] tb_last;
  logic                  tb_tick_ff;

  always_comb
  begin
    case (timebase_sel)
      ICTR_TB_100K: tb_last = `ICTR_TB_W'(DIV_100K - 1);
      ICTR_TB_10K:  tb_last = `ICTR_TB_W'(DIV_10K - 1);
      ICTR_TB_1K:   tb_last = `ICTR_TB_W'(DIV_1K - 1);
      default:      tb_last = `ICTR_TB_W'(DIV_100 - 1);
    endcase
  end

  // compare with >= so a switch to a faster rate never waits a full wrap
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      tb_cnt_ff  <= '0;
      tb_tick_ff <= 1'b0;
    end
    else if (tb_cnt_ff >= tb_last)
    begin
      tb_cnt_ff  <= '0;
      tb_tick_ff <= 1'b1;
    end
    else
    begin
      tb_cnt_ff  <= tb_cnt_ff + `ICTR_TB_W'(1);
      tb_tick_ff <= 1'b0;
    end
  end

  // ---------------- counter core ----------------
  logic       c_tick      [NCNT];
  logic       c_gate      [NCNT];
  logic       c_wr        [NCNT];
  logic       c_rd        [NCNT];
  logic       c_ptr_rst   [NCNT];
  ictr_byte_t c_rd_byte   [NCNT];
  logic       c_out       [NCNT];
  logic       c_tc        [NCNT];
  logic [1:0] cw_sel;

  assign cw_sel = core_ctrl_ff[`ICTR_CW_SEL_HI:`ICTR_CW_SEL_LO];

  // counter zero: time base or isolated input one
  assign c_tick[0] = cnt_a_clock_select ? iso_rise[1] : tb_tick_ff;
  assign c_gate[0] = cnt_a_gate_select ? iso_sync_ff[0] : cnt_a_sw_gate_ff;

  // counter one: in cascade it counts counter zero terminal pulses
  assign c_tick[1] = cascade_enable ? c_tc[0]
                   : (cnt_b_clock_select ? iso_rise[3] : tb_tick_ff);
  assign c_gate[1] = cnt_b_gate_select ? iso_sync_ff[2] : cnt_b_sw_gate_ff;

  // counter two is system-owned: free running on the time base, no port
  assign c_tick[2] = tb_tick_ff;
  assign c_gate[2] = 1'b1;

  logic cw_wr;
  assign cw_wr = wr_done && hit_ctrl;

  assign c_wr[0] = wr_done && hit_a_data;
  assign c_wr[1] = wr_done && hit_b_data;
  assign c_wr[2] = 1'b0;
  assign c_rd[0] = rd_done && hit_a_data;
  assign c_rd[1] = rd_done && hit_b_data;
  assign c_rd[2] = 1'b0;

  // a control-word write restarts the byte order of the counter it names
  assign c_ptr_rst[0] = cw_wr && (wbyte[`ICTR_CW_SEL_HI:`ICTR_CW_SEL_LO] == 2'b00);
  assign c_ptr_rst[1] = cw_wr && (wbyte[`ICTR_CW_SEL_HI:`ICTR_CW_SEL_LO] == 2'b01);
  assign c_ptr_rst[2] = 1'b0;

  generate
    for (gi = 0; gi < NCNT; gi++)
    begin : g_cnt
      ictr_counter16
      #(
        .INIT_RELOAD ((gi == 2) ? `ICTR_SYS_RELOAD : `ICTR_RST_COUNT),
        .INIT_ARMED  (gi == 2)
      )
      u_cnt
      (
        .clock     (clock),
        .resetn    (resetn),
        .tick      (c_tick[gi]),
        .gate      (c_gate[gi]),
        .wr_en     (c_wr[gi]),
        .wr_data   (wbyte),
        .rd_en     (c_rd[gi]),
        .ptr_reset (c_ptr_rst[gi]),
        .rd_byte   (c_rd_byte[gi]),
        .out_ff    (c_out[gi]),
        .tc_ff     (c_tc[gi])
      );
    end
  endgenerate

  // ---------------- control registers ----------------
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      cnt_a_sw_gate_ff <= 1'b0;
      cnt_b_sw_gate_ff <= 1'b0;
      set_a_ff         <= `ICTR_RST_SET_A;
      set_b_ff         <= `ICTR_RST_SET_B;
      core_ctrl_ff     <= `ICTR_RST_BYTE;
    end
    else if (wr_done)
    begin
      if (hit_a_start)
      begin
        cnt_a_sw_gate_ff <= wbyte[`ICTR_BIT_SW_GATE];
      end
      else if (hit_b_start)
      begin
        cnt_b_sw_gate_ff <= wbyte[`ICTR_BIT_SW_GATE];
      end
      else if (hit_a_set)
      begin
        set_a_ff <= wbyte[3:0];
      end
      else if (hit_b_set)
      begin
        set_b_ff <= wbyte[6:0];
      end
      else if (hit_ctrl && (wbyte[`ICTR_CW_SEL_HI:`ICTR_CW_SEL_LO] != 2'b10))
      begin
        core_ctrl_ff <= wbyte;
      end
    end
  end

  // ---------------- interrupt flags ----------------
  logic a_event;
  logic b_event;
  logic a_clear;
  logic b_clear;

  // in cascade only the upper half's terminal count is a 32-bit event
  assign a_event = c_tc[0] && cnt_a_irq_enable && !cascade_enable;
  assign b_event = c_tc[1] && cnt_b_irq_enable;
  assign a_clear = wr_done && hit_irq && wbyte[`ICTR_BIT_A_FLAG];
  assign b_clear = wr_done && hit_irq && wbyte[`ICTR_BIT_B_FLAG];

  // set wins over a same-cycle clear so no event is lost
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      cnt_a_irq_flag_ff <= 1'b0;
      cnt_b_irq_flag_ff <= 1'b0;
    end
    else
    begin
      cnt_a_irq_flag_ff <= a_event || (cnt_a_irq_flag_ff && !a_clear);
      cnt_b_irq_flag_ff <= b_event || (cnt_b_irq_flag_ff && !b_clear);
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      irq_line7_ff <= 1'b0;
    end
    else
    begin
      irq_line7_ff <= cnt_a_irq_flag_ff || cnt_b_irq_flag_ff || di_irq_req;
    end
  end

  // ---------------- isolated outputs ----------------
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      iso_out_ch2_ff <= 1'b0;
      iso_out_ch3_ff <= 1'b0;
    end
    else
    begin
      iso_out_ch2_ff <= cnt_a_out_route && c_out[0];
      iso_out_ch3_ff <= cnt_b_out_route && c_out[1];
    end
  end

  // ---------------- bus answer ----------------
  ictr_byte_t rd_mux;

  always_comb
  begin
    rd_mux = `ICTR_RST_BYTE;
    if (hit_irq)
    begin
      rd_mux[`ICTR_BIT_A_FLAG] = cnt_a_irq_flag_ff;
      rd_mux[`ICTR_BIT_B_FLAG] = cnt_b_irq_flag_ff;
    end
    else if (hit_a_data)
    begin
      rd_mux = c_rd_byte[0];
    end
    else if (hit_b_data)
    begin
      rd_mux = c_rd_byte[1];
    end
    else if (hit_ctrl)
    begin
      rd_mux = core_ctrl_ff;
    end
    else if (hit_a_start)
    begin
      rd_mux[`ICTR_BIT_SW_GATE]   = cnt_a_sw_gate_ff;
      rd_mux[`ICTR_BIT_OUT_STATUS] = c_out[0];
    end
    else if (hit_b_start)
    begin
      rd_mux[`ICTR_BIT_SW_GATE]   = cnt_b_sw_gate_ff;
      rd_mux[`ICTR_BIT_OUT_STATUS] = c_out[1];
    end
    else if (hit_a_set)
    begin
      rd_mux[3:0] = set_a_ff;
    end
    else if (hit_b_set)
    begin
      rd_mux[6:0] = set_b_ff;
    end
  end

  // no wait state: data, error and ready are captured at the end of setup, so ready is high in the first access cycle
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end
    else if (setup_ph)
    begin
      pready_ff  <= 1'b1;
      pslverr_ff <= !hit_any;
      prdata_ff  <= {24'h000000, rd_mux};
    end
    else
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign prdata      = prdata_ff;
  assign pready      = pready_ff;
  assign pslverr     = pslverr_ff;
  assign iso_out_ch2 = iso_out_ch2_ff;
  assign iso_out_ch3 = iso_out_ch3_ff;
  assign irq_line7   = irq_line7_ff;

endmodule

/* File: tb/ictr_field_src.sv */
`timescale 1ns/1ps

// field-side clock source: square wave only while run, else parked low
module ictr_field_src
#(
  parameter int HALF = 3
)
(
  input  wire logic clock,
  input  wire logic run,
  output logic      pulse = 1'b0
);
  int n = 0;

  always @(posedge clock)
  begin
    if (!run || n == HALF - 1)
    begin
      n <= 0;
      pulse <= run ? ~pulse : 1'b0;
    end
    else
      n <= n + 1;
  end
endmodule

/* File: tb/ictr_top_asserts.sv */
`timescale 1ns/1ps

module ictr_top_chk
#(
  parameter int unsigned ADDR_W = 12
)
(
  input wire logic              clock,
  input wire logic              resetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              di_irq_req,
  input wire logic              irq_line7
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_xfer;
    s_setup ##1 (psel && penable);
  endsequence

  AST_READY_IN_ACCESS:
    assert property (s_xfer |-> pready) else $error("no ready in access cycle");
  AST_READY_CAUSE:
    assert property (pready |-> $past(psel && !penable)) else $error("ready without setup");
  AST_READY_PULSE:
    assert property (pready |=> !pready) else $error("ready longer than one cycle");
  AST_ERR_UNALIGNED:
    assert property ((psel && !penable && paddr[1:0] != 2'b00) |=> pslverr)
      else $error("unaligned access not refused");
  AST_ERR_WITH_READY:
    assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error response");
  AST_RD_UPPER_ZERO:
    assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  AST_RD_HELD:
    assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
  AST_IRQ_DI:
    assert property (di_irq_req |=> irq_line7) else $error("input request not on line");
  // the line may also drop because the input request went away
  AST_IRQ_FALL:
    assert property ($fell(irq_line7) && $past(resetn) |->
      ($past(psel && penable && pwrite, 2) || $past(psel && penable && pwrite, 3)
      || $past(di_irq_req, 2))
      && !$past(di_irq_req)) else $error("line dropped without clear");
endmodule

/* File: tb/ictr_top_bench.sv */
`timescale 1ns/1ps
`include "ictr_defines.svh"

module ictr_top_bench;
  localparam int          H1       = 3;
  localparam int          H3       = 5;
  localparam int          DV [4]   = '{4, 8, 16, 32};
  localparam logic [11:0] FLG      = {`ICTR_IDX_IRQ_FLAG, 2'b00};
  localparam logic [11:0] DA       = {`ICTR_IDX_CNT_A_DATA, 2'b00};
  localparam logic [11:0] DB       = {`ICTR_IDX_CNT_B_DATA, 2'b00};
  localparam logic [11:0] CW       = {`ICTR_IDX_CORE_CTRL, 2'b00};
  localparam logic [11:0] STA      = {`ICTR_IDX_CNT_A_START, 2'b00};
  localparam logic [11:0] STB      = {`ICTR_IDX_CNT_B_START, 2'b00};
  localparam logic [11:0] SETA     = {`ICTR_IDX_CNT_A_SET, 2'b00};
  localparam logic [11:0] SETB     = {`ICTR_IDX_CNT_B_SET, 2'b00};
  localparam logic [11:0] REGS [6] = '{FLG, STA, STB, SETA, SETB, CW};

  logic        clock, resetn, psel, penable, pwrite, pready, pslverr, e;
  logic        g0, g2, c1, c3, r1, r3, di, o2, o3, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [7:0]  q;
  int          failures, n_checks, c;

  ictr_top #(.DIV_100K(DV[0]), .DIV_10K(DV[1]), .DIV_1K(DV[2]), .DIV_100(DV[3])) uut
  (
    .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .iso_in_ch0(g0), .iso_in_ch1(c1), .iso_in_ch2(g2), .iso_in_ch3(c3),
    .di_irq_req(di), .iso_out_ch2(o2), .iso_out_ch3(o3), .irq_line7(irq)
  );
  ictr_field_src #(.HALF(H1)) src1 (.clock(clock), .run(r1), .pulse(c1));
  ictr_field_src #(.HALF(H3)) src3 (.clock(clock), .run(r3), .pulse(c3));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task close_out;
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [7:0] s, input logic [7:0] x);
    n_checks++;
    if (s !== x)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask

  // one setup cycle, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      failures++;
      close_out();
    end
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a);
    apb(1'b0, a, 8'h00);
  endtask

  // cycles up to the next falling edge of a routed output; lim when none
  task automatic fall(input logic b, input int lim);
    logic p;
    p = 1'b0;
    c = 0;
    while (c < lim)
    begin
      @(posedge clock);
      c++;
      if (p === 1'b1 && (b ? o3 : o2) === 1'b0)
        break;
      p = b ? o3 : o2;
    end
  endtask

  task wirq;
    c = 0;
    while (irq !== 1'b1 && c < 600)
    begin
      @(posedge clock);
      c++;
    end
    if (c >= 600)
    begin
      failures++;
      close_out();
    end
  endtask

  initial
  begin
    {resetn, psel, penable, pwrite, g0, g2, r1, r3, di} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    failures = 0;
    n_checks = 0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    foreach (REGS[i])
    begin
      rd(REGS[i]);
      chk(q & 8'hef, 8'h00);
    end
    rd(STA);
    chk(q, 8'h10);
    wr(SETA, 8'hff);
    rd(SETA);
    chk(q, 8'h0f);
    wr(SETB, 8'hff);
    rd(SETB);
    chk(q, 8'h7f);
    wr(SETB, 8'h00);
    wr(STA, 8'hff);
    rd(STA);
    chk(q & 8'hef, 8'h01);
    wr(CW, 8'h5a);
    rd(CW);
    chk(q, 8'h5a);
    rd(12'h900);
    chk({7'h0, e}, 8'h01);
    wr(12'h821, 8'h01);
    chk({7'h0, e}, 8'h01);
    pstrb <= 4'h0;
    wr(SETA, 8'h08);
    pstrb <= 4'hf;
    rd(SETA);
    chk(q, 8'h0f);
    // smallest legal count, so each period is exactly two ticks
    wr(DA, 8'h02);
    wr(DA, 8'h00);
    wr(SETA, 8'h04);
    for (int i = 0; i < 4; i++)
    begin
      wr(SETB, 8'(i << 4));
      repeat (3) fall(1'b0, 400);
      chk(c[7:0], 8'(2 * DV[i]));
    end
    wr(SETA, 8'h06);
    fall(1'b0, 150);
    chk(c[7:0], 8'd150);
    // frozen with the output low: status shows it
    rd(STA);
    chk(q, 8'h01);
    g0 <= 1'b1;
    repeat (2) fall(1'b0, 400);
    chk(c[7:0], 8'(2 * DV[3]));
    // still counting, but unrouted: the isolated output must stay quiet
    wr(SETA, 8'h00);
    @(posedge clock);
    fall(1'b0, 150);
    chk(c[7:0], 8'd150);
    wr(SETA, 8'h05);
    r1 <= 1'b1;
    repeat (3) fall(1'b0, 400);
    chk(c[7:0], 8'(4 * H1));
    r1 <= 1'b0;
    wr(SETA, 8'h04);
    wr(FLG, 8'h0c);
    repeat (2) fall(1'b0, 400);
    rd(FLG);
    chk(q, 8'h00);
    wr(SETA, 8'h0c);
    repeat (2) fall(1'b0, 400);
    rd(FLG);
    chk(q, 8'h04);
    chk({7'h0, irq}, 8'h01);
    wr(STA, 8'h00);
    wr(FLG, 8'hfb);
    rd(FLG);
    chk(q, 8'h04);
    wr(FLG, 8'h04);
    rd(FLG);
    chk(q, 8'h00);
    chk({7'h0, irq}, 8'h00);
    di <= 1'b1;
    repeat (3) @(posedge clock);
    chk({7'h0, irq}, 8'h01);
    di <= 1'b0;
    wr(DB, 8'h02);
    wr(DB, 8'h00);
    wr(SETB, 8'h0f);
    g2 <= 1'b1;
    r3 <= 1'b1;
    wirq();
    rd(FLG);
    chk(q, 8'h08);
    repeat (2) fall(1'b1, 400);
    chk(c[7:0], 8'(4 * H3));
    g2 <= 1'b0;
    fall(1'b1, 150);
    chk(c[7:0], 8'd150);
    r3 <= 1'b0;
    // cascade: the low half must never flag, only the joined count
    wr(FLG, 8'h0c);
    wr(SETA, 8'h0c);
    wr(SETB, 8'h78);
    wr(STB, 8'h01);
    wr(STA, 8'h01);
    wirq();
    rd(FLG);
    chk(q, 8'h08);
    close_out();
  end
endmodule

bind ictr_top ictr_top_chk #(.ADDR_W(ADDR_W)) chk_i
(
  .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .di_irq_req(di_irq_req), .irq_line7(irq_line7)
);
